// file: inc/cfg_pkg.sv
// Shared constants and types for the unlock key and direct configuration logic
package cfg_pkg;

    // ****************************************
    // Host I/O write and per-device storage
    // ****************************************
    typedef struct packed {
        logic valid;        // One-cycle write strobe
        logic [15:0] addr;  // I/O address
        logic [7:0] data;   // Write data
    } io_wr_s;

    typedef struct packed {
        logic [15:0] base0;
        logic [15:0] base1;
        logic [15:0] base2;
        logic [7:0] irq0;
        logic [7:0] irq1;
        logic [7:0] dma0;
        logic [7:0] dma1;
        logic active;
    } dev_cfg_s;

    // ****************************************
    // Ports, sizes and reset values
    // ****************************************
    localparam logic [15:0] CFG_PORT = 16'h0279;
    localparam int NUM_DEV = 5;
    localparam logic [7:0] NUM_DEV_B = 8'h05;
    localparam logic [4:0] KEY_FIRST = 5'h00;
    localparam logic [4:0] KEY_SECOND = 5'h01;
    localparam logic [4:0] KEY_LAST = 5'h1F;
    localparam logic [4:0] KEY_STEP = 5'h01;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam dev_cfg_s DEV_RST = '0;

    // Unlock key in match order
    localparam logic [7:0] UNLOCK_KEY [0:31] = '{
        8'h96, 8'h35, 8'h9A, 8'hCD, 8'hE6, 8'hF3, 8'h79, 8'hBC,
        8'h5E, 8'hAF, 8'h57, 8'h2B, 8'h15, 8'h8A, 8'hC5, 8'hE2,
        8'hF1, 8'hF8, 8'h7C, 8'h3E, 8'h9F, 8'h4F, 8'h27, 8'h13,
        8'h09, 8'h84, 8'h42, 8'hA1, 8'hD0, 8'h68, 8'h34, 8'h1A};

    // ****************************************
    // Command bytes and control port values
    // ****************************************
    localparam logic [7:0] CMD_CSN = 8'h06;
    localparam logic [7:0] CMD_LDN = 8'h15;
    localparam logic [7:0] CMD_BASE0 = 8'h47;
    localparam logic [7:0] CMD_BASE1 = 8'h48;
    localparam logic [7:0] CMD_BASE2 = 8'h42;
    localparam logic [7:0] CMD_IRQ0 = 8'h22;
    localparam logic [7:0] CMD_IRQ1 = 8'h27;
    localparam logic [7:0] CMD_DMA0 = 8'h2A;
    localparam logic [7:0] CMD_DMA1 = 8'h25;
    localparam logic [7:0] CMD_ACT = 8'h33;
    localparam logic [7:0] CMD_CHIP = 8'h79;
    localparam logic [7:0] ACT_ON = 8'h01;
    localparam logic [7:0] CTRL_DEV = 8'h02;
    localparam logic [15:0] CTRL_CMD_OFS = 16'h0005;
    localparam logic [7:0] CTRL_PNP_OFF = 8'h55;
    localparam logic [7:0] CTRL_DOWNLOAD = 8'hAA;

endpackage : cfg_pkg

// file: logic/key_matcher.sv
// Unlock key byte sequence matcher
`timescale 1ns/100ps
module key_matcher
    import cfg_pkg::*;
(
    input wire logic clk,            // System clock
    input wire logic rst,            // Async reset, active high
    input wire logic byte_valid,     // Write to configuration port
    input wire logic [7:0] byte_data, // Written byte
    output logic key_hit             // Pulse on last key byte
);

    logic [4:0] idx_reg;
    logic [4:0] idx_next;

    // Next match position, restart on a wrong byte
    always_comb
    begin
        idx_next = idx_reg;
        key_hit = 1'b0;
        if (byte_valid)
        begin
            if (byte_data == UNLOCK_KEY[idx_reg])
            begin
                if (idx_reg == KEY_LAST)
                begin
                    key_hit = 1'b1;
                    idx_next = KEY_FIRST;
                end
                else
                begin
                    idx_next = 5'(idx_reg + KEY_STEP);
                end
            end
            else if (byte_data == UNLOCK_KEY[KEY_FIRST])
            begin
                idx_next = KEY_SECOND;
            end
            else
            begin
                idx_next = KEY_FIRST;
            end
        end
    end

    // Match position register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            idx_reg <= KEY_FIRST;
        else
            idx_reg <= idx_next;
    end

    // ****************************************
    // Assertions
    // ****************************************
    a_key_restart: assert property (@(posedge clk) disable iff (rst)
        byte_valid && byte_data != UNLOCK_KEY[idx_reg] && byte_data != UNLOCK_KEY[KEY_FIRST]
        |=> idx_reg == KEY_FIRST)
        else $error("key match did not restart");

    a_key_advance: assert property (@(posedge clk) disable iff (rst)
        byte_valid && byte_data == UNLOCK_KEY[idx_reg] && idx_reg != KEY_LAST
        |=> idx_reg == $past(idx_reg) + KEY_STEP)
        else $error("key match did not advance");

endmodule : key_matcher

// file: logic/key_unlock_direct_config.sv
// Unlock key detection and direct configuration command interpreter
`timescale 1ns/100ps
module key_unlock_direct_config
    import cfg_pkg::*;
(
    input wire logic clk,                       // 100 MHz system clock
    input wire logic rst,                       // Reset driver or power-up, active high
    input wire io_wr_s host_wr,                 // Host I/O write
    input wire logic std_key_seen,              // Standard initiation key detected
    output logic std_key_accept,                // Initiation key passed on
    output logic config_mode,                   // In configuration mode
    output logic chip_active,                   // Chip activated
    output logic pnp_disabled,                  // Plug and Play participation off
    output logic download_start,                // Pulse: resource download begins
    output logic [7:0] csn,                     // Card select number
    output logic [7:0] ldn,                     // Selected logical device
    output dev_cfg_s [NUM_DEV-1:0] dev_cfg,     // Per-device resources
    output logic [NUM_DEV-1:0] dev_enable       // Device answers host accesses
);

    // ****************************************
    // State
    // ****************************************
    typedef enum {ST_LOCKED, ST_CMD, ST_VAL, ST_HI, ST_LO} cmd_state_e;

    cmd_state_e state_reg;
    cmd_state_e state_next;
    logic [7:0] cmd_reg;
    logic [7:0] cmd_next;
    logic [7:0] hi_reg;
    logic [7:0] hi_next;
    logic [7:0] csn_reg;
    logic [7:0] csn_next;
    logic [7:0] ldn_reg;
    logic [7:0] ldn_next;
    logic chip_reg;
    logic chip_next;
    logic pnp_off_reg;
    logic pnp_off_next;
    logic ctrl_set_reg;
    logic ctrl_set_next;
    logic dl_reg;
    logic dl_next;
    dev_cfg_s [NUM_DEV-1:0] dev_reg;
    dev_cfg_s [NUM_DEV-1:0] dev_next;

    logic port_wr;
    logic key_hit;
    logic ctrl_wr;
    logic ldn_ok;
    logic [2:0] sel;
    logic [15:0] word_val;

    // Writes to the configuration port and the control port
    assign port_wr = host_wr.valid && host_wr.addr == CFG_PORT;
    assign ldn_ok = ldn_reg < NUM_DEV_B;
    assign sel = ldn_reg[2:0];
    assign ctrl_wr = host_wr.valid && ctrl_set_reg
        && host_wr.addr == 16'(dev_reg[CTRL_DEV[2:0]].base0 + CTRL_CMD_OFS);
    assign word_val = {hi_reg, host_wr.data};

    // Key matcher sees every port write, in any mode
    key_matcher i_key_matcher (
        .clk(clk),
        .rst(rst),
        .byte_valid(port_wr),
        .byte_data(host_wr.data),
        .key_hit(key_hit)
    );

    // ****************************************
    // Command interpreter
    // ****************************************

    // Next values of the interpreter and configuration store
    always_comb
    begin
        state_next = state_reg;
        cmd_next = cmd_reg;
        hi_next = hi_reg;
        csn_next = csn_reg;
        ldn_next = ldn_reg;
        chip_next = chip_reg;
        dev_next = dev_reg;
        ctrl_set_next = ctrl_set_reg;
        if (key_hit)
        begin
            state_next = ST_CMD;
        end
        else if (port_wr)
        begin
            case (state_reg)
                ST_LOCKED:
                begin
                    state_next = ST_LOCKED;
                end
                ST_CMD:
                begin
                    cmd_next = host_wr.data;
                    case (host_wr.data)
                        CMD_CSN, CMD_LDN, CMD_IRQ0, CMD_IRQ1,
                        CMD_DMA0, CMD_DMA1, CMD_ACT:
                            state_next = ST_VAL;
                        CMD_BASE0, CMD_BASE1, CMD_BASE2:
                            state_next = ST_HI;
                        CMD_CHIP:
                        begin
                            chip_next = 1'b1;
                            state_next = ST_LOCKED;
                        end
                        default:
                            state_next = ST_CMD;
                    endcase
                end
                ST_VAL:
                begin
                    state_next = ST_CMD;
                    if (cmd_reg == CMD_CSN)
                        csn_next = host_wr.data;
                    else if (cmd_reg == CMD_LDN)
                        ldn_next = host_wr.data;
                    else if (ldn_ok)
                    begin
                        case (cmd_reg)
                            CMD_IRQ0: dev_next[sel].irq0 = host_wr.data;
                            CMD_IRQ1: dev_next[sel].irq1 = host_wr.data;
                            CMD_DMA0: dev_next[sel].dma0 = host_wr.data;
                            CMD_DMA1: dev_next[sel].dma1 = host_wr.data;
                            CMD_ACT: dev_next[sel].active = host_wr.data == ACT_ON;
                            default: dev_next = dev_reg;
                        endcase
                    end
                end
                ST_HI:
                begin
                    hi_next = host_wr.data;
                    state_next = ST_LO;
                end
                ST_LO:
                begin
                    state_next = ST_CMD;
                    if (ldn_ok)
                    begin
                        case (cmd_reg)
                            CMD_BASE0:
                            begin
                                dev_next[sel].base0 = word_val;
                                if (ldn_reg == CTRL_DEV)
                                    ctrl_set_next = 1'b1;
                            end
                            CMD_BASE1: dev_next[sel].base1 = word_val;
                            CMD_BASE2: dev_next[sel].base2 = word_val;
                            default: dev_next = dev_reg;
                        endcase
                    end
                end
                default:
                    state_next = ST_LOCKED;
            endcase
        end
    end

    // Interpreter and configuration registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= ST_LOCKED;
            cmd_reg <= BYTE_ZERO;
            hi_reg <= BYTE_ZERO;
            csn_reg <= BYTE_ZERO;
            ldn_reg <= BYTE_ZERO;
            chip_reg <= 1'b0;
            ctrl_set_reg <= 1'b0;
            dev_reg <= {NUM_DEV{DEV_RST}};
        end
        else
        begin
            state_reg <= state_next;
            cmd_reg <= cmd_next;
            hi_reg <= hi_next;
            csn_reg <= csn_next;
            ldn_reg <= ldn_next;
            chip_reg <= chip_next;
            ctrl_set_reg <= ctrl_set_next;
            dev_reg <= dev_next;
        end
    end

    // ****************************************
    // Control port commands
    // ****************************************

    // Disable is sticky until reset; download start is one pulse
    always_comb
    begin
        pnp_off_next = pnp_off_reg;
        dl_next = 1'b0;
        if (ctrl_wr && host_wr.data == CTRL_PNP_OFF)
            pnp_off_next = 1'b1;
        if (ctrl_wr && host_wr.data == CTRL_DOWNLOAD)
            dl_next = 1'b1;
    end

    // Control port registers; disable cleared only by reset, download pulse clears itself next cycle
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pnp_off_reg <= 1'b0;
            dl_reg <= 1'b0;
        end
        else
        begin
            pnp_off_reg <= pnp_off_next;
            dl_reg <= dl_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign config_mode = state_reg != ST_LOCKED;
    assign chip_active = chip_reg;
    assign pnp_disabled = pnp_off_reg;
    assign download_start = dl_reg;
    assign csn = csn_reg;
    assign ldn = ldn_reg;
    assign dev_cfg = dev_reg;
    assign std_key_accept = std_key_seen && !pnp_off_reg;

    // Per-device enable after chip activation
    genvar gi;
    generate
        for (gi = 0; gi < NUM_DEV; gi++)
        begin : g_dev
            assign dev_enable[gi] = chip_reg && dev_reg[gi].active;

            a_dev_silent: assert property (@(posedge clk) disable iff (rst)
                $rose(dev_enable[gi]) |-> $past(port_wr) && chip_reg && dev_reg[gi].active)
                else $error("device enabled without activate or chip command");
        end
    endgenerate

    // ****************************************
    // Assertions
    // ****************************************
    a_key_enter: assert property (@(posedge clk) disable iff (rst)
        key_hit |=> config_mode && state_reg == ST_CMD)
        else $error("key did not unlock");

    a_csn_load: assert property (@(posedge clk) disable iff (rst)
        port_wr && !key_hit && state_reg == ST_VAL && cmd_reg == CMD_CSN
        |=> csn == $past(host_wr.data))
        else $error("card number not loaded");

    a_chip_act: assert property (@(posedge clk) disable iff (rst)
        port_wr && !key_hit && state_reg == ST_CMD && host_wr.data == CMD_CHIP
        |=> chip_active && !config_mode)
        else $error("chip activate failed");

    a_pnp_off: assert property (@(posedge clk) disable iff (rst)
        ctrl_wr && host_wr.data == CTRL_PNP_OFF |=> pnp_disabled)
        else $error("disable command lost");

    a_pnp_sticky: assert property (@(posedge clk) disable iff (rst)
        pnp_disabled |=> pnp_disabled [*2])
        else $error("disable cleared without reset");

    a_std_block: assert property (@(posedge clk) disable iff (rst)
        pnp_disabled |-> !std_key_accept)
        else $error("initiation key passed while disabled");

    a_locked_ignore: assert property (@(posedge clk) disable iff (rst)
        !config_mode && port_wr && !key_hit |=> $stable(csn) && $stable(ldn) && !config_mode)
        else $error("command taken while locked");

    a_two_bytes: assert property (@(posedge clk) disable iff (rst)
        port_wr && !key_hit && state_reg == ST_CMD && host_wr.data == CMD_BASE0
        |=> state_reg == ST_HI)
        else $error("base command byte count wrong");

    c_unlock: cover property (@(posedge clk) disable iff (rst) key_hit);
    c_chip_on: cover property (@(posedge clk) disable iff (rst) $rose(chip_active));
    c_pnp_off: cover property (@(posedge clk) disable iff (rst) $rose(pnp_disabled));
    c_download: cover property (@(posedge clk) disable iff (rst) download_start);

endmodule : key_unlock_direct_config

// file: verification/host_model.sv
// Host model that writes I/O cycles to the configuration and control ports
`timescale 1ns/100ps
module host_model
    import cfg_pkg::*;
(
    input wire logic clk, // System clock
    output io_wr_s host_wr // Host I/O write
);
    // ****************************************
    // Write cycles, launched at the falling edge
    // ****************************************

    // Bus idle at time zero
    initial
    begin
        host_wr = '{valid: 1'b0, addr: 16'h0000, data: 8'h00};
    end

    // One write, held past the rising edge until the next task call at a falling edge
    task automatic wr(input logic [15:0] addr, input logic [7:0] data);
        @(negedge clk);
        host_wr.valid = 1'b1;
        host_wr.addr = addr;
        host_wr.data = data;
    endtask : wr

    // Configuration port write
    task automatic wr_port(input logic [7:0] data);
        wr(CFG_PORT, data);
    endtask : wr_port

    // Release the bus; released lines show a changing pattern
    task automatic idle();
        @(negedge clk);
        host_wr.valid = 1'b0;
        host_wr.addr = ~host_wr.addr;
        host_wr.data = ~host_wr.data;
    endtask : idle

    // First key bytes in order; one such device per system
    task automatic send_key(input int count);
        for (int i = 0; i < count; i++)
        begin
            wr_port(UNLOCK_KEY[i]);
        end
    endtask : send_key

    // Select, resources, activate for one device; repeated per device
    task automatic cfg_dev(input logic [7:0] ld, input logic [15:0] b0);
        wr_port(CMD_LDN);
        wr_port(ld);
        wr_port(CMD_BASE0);
        wr_port(b0[15:8]);
        wr_port(b0[7:0]);
        wr_port(CMD_BASE1);
        wr_port(8'hA5);
        wr_port(ld);
        wr_port(CMD_BASE2);
        wr_port(8'h5A);
        wr_port(ld);
        wr_port(CMD_IRQ0);
        wr_port(8'h10 + ld);
        wr_port(CMD_IRQ1);
        wr_port(8'h20 + ld);
        wr_port(CMD_DMA0);
        wr_port(8'h30 + ld);
        wr_port(CMD_DMA1);
        wr_port(8'h40 + ld);
        wr_port(CMD_ACT);
        wr_port(ACT_ON);
    endtask : cfg_dev
endmodule : host_model

// file: verification/test_key_unlock_direct_config.sv
// Self-checking testbench for the unlock key and direct configuration logic
`timescale 1ns/100ps
module test_key_unlock_direct_config
    import cfg_pkg::*;
;
    // ****************************************
    // Signals, clock and instances
    // ****************************************
    logic clk;
    logic rst;
    io_wr_s host_wr;
    logic std_key_seen;
    logic std_key_accept;
    logic config_mode;
    logic chip_active;
    logic pnp_disabled;
    logic download_start;
    logic [7:0] csn;
    logic [7:0] ldn;
    dev_cfg_s [NUM_DEV-1:0] dev_cfg;
    logic [NUM_DEV-1:0] dev_enable;
    int err_total = 0;
    int total_checks = 0;

    // Free-running 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    host_model i_host_model (.clk(clk), .host_wr(host_wr));

    key_unlock_direct_config i_key_unlock_direct_config (
        .clk(clk),
        .rst(rst),
        .host_wr(host_wr),
        .std_key_seen(std_key_seen),
        .std_key_accept(std_key_accept),
        .config_mode(config_mode),
        .chip_active(chip_active),
        .pnp_disabled(pnp_disabled),
        .download_start(download_start),
        .csn(csn),
        .ldn(ldn),
        .dev_cfg(dev_cfg),
        .dev_enable(dev_enable)
    );

    // ****************************************
    // Compare and closing tasks
    // ****************************************
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic test_done();
        $display("Checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
        begin
            $display("TEST PASSED");
        end
        else
        begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done

    // Base address 0 per device; device 2 lands on 0120h
    function automatic logic [15:0] base0_of(input int ld);
        return 16'h00E0 + 16'(ld * 32);
    endfunction : base0_of

    // Standard key pulse and check of its pass-through
    task automatic pulse_std(input logic exp);
        std_key_seen = 1'b1;
        #1;
        chk("std_key_accept", std_key_accept, exp);
        @(negedge clk);
        std_key_seen = 1'b0;
    endtask : pulse_std

    // ****************************************
    // Scenarios
    // ****************************************

    // Locked: commands ignored, broken key does not unlock
    task automatic t_locked();
        chk("config_mode", config_mode, 1'b0);
        chk("chip_active", chip_active, 1'b0);
        i_host_model.wr_port(CMD_CSN);
        i_host_model.wr_port(8'h05);
        i_host_model.wr(CTRL_CMD_OFS, CTRL_PNP_OFF);
        i_host_model.send_key(16);
        i_host_model.wr_port(8'h00);
        for (int i = 16; i < 32; i++)
        begin
            i_host_model.wr_port(UNLOCK_KEY[i]);
        end
        i_host_model.idle();
        @(negedge clk);
        chk("csn", csn, 8'h00);
        chk("config_mode", config_mode, 1'b0);
        chk("pnp_disabled", pnp_disabled, 1'b0);
        $display("t_locked done");
    endtask : t_locked

    // Key broken by 96h restarts at the second byte, then unlocks
    task automatic t_unlock();
        i_host_model.send_key(5);
        i_host_model.wr_port(UNLOCK_KEY[0]);
        for (int i = 1; i < 32; i++)
        begin
            i_host_model.wr_port(UNLOCK_KEY[i]);
        end
        i_host_model.idle();
        @(negedge clk);
        chk("config_mode", config_mode, 1'b1);
        $display("t_unlock done");
    endtask : t_unlock

    // Card number, four devices, out-of-range select, chip activate
    task automatic t_program();
        i_host_model.wr_port(8'hFF);
        i_host_model.wr_port(CMD_CSN);
        i_host_model.wr_port(8'h01);
        for (int ld = 0; ld < 4; ld++)
        begin
            i_host_model.cfg_dev(8'(ld), base0_of(ld));
        end
        i_host_model.wr_port(CMD_LDN);
        i_host_model.wr_port(8'h03);
        i_host_model.wr_port(CMD_ACT);
        i_host_model.wr_port(BYTE_ZERO);
        i_host_model.wr_port(CMD_LDN);
        i_host_model.wr_port(8'h07);
        i_host_model.wr_port(CMD_IRQ0);
        i_host_model.wr_port(8'h77);
        i_host_model.idle();
        chk("dev_enable", dev_enable, 5'h00);
        chk("csn", csn, 8'h01);
        chk("ldn", ldn, 8'h07);
        i_host_model.wr_port(CMD_CHIP);
        i_host_model.idle();
        chk("chip_active", chip_active, 1'b1);
        chk("config_mode", config_mode, 1'b0);
        chk("dev_enable", dev_enable, 5'h07);
        for (int ld = 0; ld < 4; ld++)
        begin
            chk("base0", dev_cfg[ld].base0, base0_of(ld));
            chk("base1", dev_cfg[ld].base1, {8'hA5, 8'(ld)});
            chk("base2", dev_cfg[ld].base2, {8'h5A, 8'(ld)});
            chk("irq0", dev_cfg[ld].irq0, 8'h10 + 8'(ld));
            chk("irq1", dev_cfg[ld].irq1, 8'h20 + 8'(ld));
            chk("dma0", dev_cfg[ld].dma0, 8'h30 + 8'(ld));
            chk("dma1", dev_cfg[ld].dma1, 8'h40 + 8'(ld));
            chk("active", dev_cfg[ld].active, 1'(ld != 3));
        end
        chk("dev4 base0", dev_cfg[4].base0, 16'h0000);
        chk("dev4 irq0", dev_cfg[4].irq0, 8'h00);
        $display("t_program done");
    endtask : t_program

    // Control port: download pulse, disable, key still unlocks
    task automatic t_control();
        pulse_std(1'b1);
        i_host_model.wr(base0_of(2) + CTRL_CMD_OFS, CTRL_DOWNLOAD);
        i_host_model.idle();
        chk("download_start", download_start, 1'b1);
        @(negedge clk);
        chk("download_start", download_start, 1'b0);
        i_host_model.wr(base0_of(2) + CTRL_CMD_OFS, CTRL_PNP_OFF);
        i_host_model.idle();
        chk("pnp_disabled", pnp_disabled, 1'b1);
        pulse_std(1'b0);
        i_host_model.send_key(32);
        i_host_model.idle();
        @(negedge clk);
        chk("config_mode", config_mode, 1'b1);
        chk("dev_enable", dev_enable, 5'h07);
        chk("pnp_disabled", pnp_disabled, 1'b1);
        i_host_model.wr_port(CMD_LDN);
        i_host_model.wr_port(8'h03);
        i_host_model.wr_port(CMD_ACT);
        i_host_model.wr_port(ACT_ON);
        i_host_model.wr_port(CMD_CHIP);
        i_host_model.idle();
        chk("dev_enable", dev_enable, 5'h0F);
        chk("config_mode", config_mode, 1'b0);
        $display("t_control done");
    endtask : t_control

    // Reset restores participation and clears state
    task automatic t_reset();
        @(negedge clk);
        rst = 1'b1;
        @(negedge clk);
        chk("config_mode", config_mode, 1'b0);
        chk("csn", csn, 8'h00);
        @(negedge clk);
        rst = 1'b0;
        chk("pnp_disabled", pnp_disabled, 1'b0);
        chk("chip_active", chip_active, 1'b0);
        chk("dev_enable", dev_enable, 5'h00);
        pulse_std(1'b1);
        i_host_model.send_key(32);
        i_host_model.idle();
        chk("config_mode", config_mode, 1'b1);
        $display("t_reset done");
    endtask : t_reset

    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial
    begin
        rst = 1'b1;
        std_key_seen = 1'b0;
        repeat (6) @(negedge clk);
        rst = 1'b0;
        t_locked();
        t_unlock();
        t_program();
        t_control();
        t_reset();
        test_done();
    end

    // Run takes well under 400 cycles
    initial
    begin
        #20000;
        err_total++;
        test_done();
    end
endmodule : test_key_unlock_direct_config
